// ---- src/ofr_pkg.sv ----
// Package of constants and carrier types for the opcode fetch and refresh sequencer
package ofr_pkg;
  // Sequencer states; phase_hi splits each state into two half-phases
  typedef enum logic [2:0] {
    ST_T1 = 3'b000,
    ST_T2 = 3'b001,
    ST_TW = 3'b010,
    ST_T3 = 3'b011,
    ST_T4 = 3'b100
  } ofr_state_type;
  // Widths and reset values
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ROW_W = 7;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_REFRESH = 8'h00;
  localparam logic [15:0] BUS_IDLE = 16'hffff;
  localparam logic [7:0] DATA_IDLE = 8'hff;
  // Refresh budget: every one of 128 rows within 2 ms
  localparam int REFRESH_ROWS = 128;
  localparam int REFRESH_PERIOD_MS = 2;
  // Clock divider: machine half-states advance on a tick from the 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int STATE_NS = 280;
  localparam int TICK_DIV = (STATE_NS * CLK_MHZ) / 1000;
  // Bus outputs carried together
  typedef struct packed {
    logic [15:0] addr;
    logic fetch_indicator_n;
    logic memory_request_n;
    logic read_n;
    logic refresh_strobe_n;
  } ofr_bus_type;
endpackage : ofr_pkg

// ---- src/ofr_tick.sv ----
// Half-state tick divider producing a one-cycle enable every DIV clocks
`timescale 1ns/1ps
module ofr_tick #(
  parameter int DIV = ofr_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Half-state enable pulse
  output logic tick
);
  // Whole state of the divider
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ofr_tick_state_type;
  ofr_tick_state_type st_ff;
  ofr_tick_state_type nxt_st;
  // Count down DIV cycles, then pulse once
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 16'h0000) begin
      nxt_st.cnt = 16'(DIV - 1);
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
  end
  // Register the divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
endmodule : ofr_tick

// ---- src/ofr_seq.sv ----
// Opcode fetch machine cycle sequencer with embedded refresh
`timescale 1ns/1ps
module ofr_seq #(
  parameter int DIV = ofr_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Memory-side inputs (from pins)
  input wire logic wait_n,
  input wire logic [7:0] data_in,
  // Memory-side outputs
  output logic [15:0] addr,
  output logic fetch_indicator_n,
  output logic memory_request_n,
  output logic read_n,
  output logic refresh_strobe_n,
  // Core side: fetched opcode and its strobe, wait-state flag and refresh register
  output logic [7:0] opcode,
  output logic opcode_valid,
  output logic inserted_wait_state,
  output logic [7:0] refresh_reg
);
  // Whole module state
  typedef struct packed {
    ofr_pkg::ofr_state_type state;
    logic phase_hi;
    logic [15:0] pc;
    logic [7:0] rr;
    logic [7:0] ir;
    logic ir_valid;
    logic wait_s1;
    logic wait_s2;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    ofr_pkg::ofr_bus_type bus;
  } ofr_seq_state_type;
  ofr_seq_state_type st_ff;
  ofr_seq_state_type nxt_st;
  logic tick;

  // Half-state pacing
  ofr_tick #(.DIV(DIV)) i_ofr_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Next refresh register: low row bits wrap, top bit kept
  function automatic logic [7:0] next_row(input logic [7:0] r);
    next_row = {r[7], 7'(r[6:0] + 7'h01)};
  endfunction : next_row

  // Sequencer next state and bus drive
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ir_valid = 1'b0;
    // Pins pass two flops; stage one only feeds stage two
    nxt_st.wait_s1 = wait_n;
    nxt_st.wait_s2 = st_ff.wait_s1;
    nxt_st.d_s1 = data_in;
    nxt_st.d_s2 = st_ff.d_s1;
    if (tick) begin
      nxt_st.phase_hi = ~st_ff.phase_hi;
      if (st_ff.phase_hi) begin
        // Second half done: move to next state
        case (st_ff.state)
          ofr_pkg::ST_T1: nxt_st.state = ofr_pkg::ST_T2;
          ofr_pkg::ST_T2, ofr_pkg::ST_TW: begin
            // Wait sampled at end of T2 and each wait state
            if (st_ff.wait_s2) begin
              nxt_st.state = ofr_pkg::ST_T3;
              nxt_st.ir = st_ff.d_s2;
              nxt_st.ir_valid = 1'b1;
            end else begin
              nxt_st.state = ofr_pkg::ST_TW;
            end
          end
          ofr_pkg::ST_T3: nxt_st.state = ofr_pkg::ST_T4;
          ofr_pkg::ST_T4: begin
            // Next machine cycle; only fetches are modelled, so fetch next opcode
            nxt_st.state = ofr_pkg::ST_T1;
            nxt_st.pc = st_ff.pc + 16'h0001;
            nxt_st.rr = next_row(st_ff.rr);
          end
          default: nxt_st.state = ofr_pkg::ST_T1;
        endcase
      end
    end
    // Bus drive from the state being entered
    nxt_st.bus.fetch_indicator_n = 1'b1;
    nxt_st.bus.memory_request_n = 1'b1;
    nxt_st.bus.read_n = 1'b1;
    nxt_st.bus.refresh_strobe_n = 1'b1;
    nxt_st.bus.addr = nxt_st.pc;
    case (nxt_st.state)
      ofr_pkg::ST_T1, ofr_pkg::ST_T2, ofr_pkg::ST_TW: begin
        nxt_st.bus.addr = nxt_st.pc;
        nxt_st.bus.fetch_indicator_n = 1'b0;
        nxt_st.bus.memory_request_n = 1'b0;
        nxt_st.bus.read_n = 1'b0;
      end
      ofr_pkg::ST_T3: begin
        // Refresh address replaces fetch address; request drops second half
        nxt_st.bus.addr = {9'h000, nxt_st.rr[6:0]};
        nxt_st.bus.refresh_strobe_n = 1'b0;
        nxt_st.bus.memory_request_n = ~nxt_st.phase_hi;
      end
      ofr_pkg::ST_T4: begin
        // Request released, refresh address and strobe still held
        nxt_st.bus.addr = {9'h000, nxt_st.rr[6:0]};
        nxt_st.bus.refresh_strobe_n = 1'b0;
        nxt_st.bus.memory_request_n = 1'b1;
      end
      default: begin
        nxt_st.bus.addr = nxt_st.pc;
      end
    endcase
  end

  // Register the whole state; reset idles every control high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.state <= ofr_pkg::ST_T1;
      st_ff.phase_hi <= 1'b0;
      st_ff.pc <= ofr_pkg::RESET_PC;
      st_ff.rr <= ofr_pkg::RESET_REFRESH;
      st_ff.ir <= 8'h00;
      st_ff.ir_valid <= 1'b0;
      st_ff.wait_s1 <= 1'b1;
      st_ff.wait_s2 <= 1'b1;
      st_ff.d_s1 <= ofr_pkg::DATA_IDLE;
      st_ff.d_s2 <= ofr_pkg::DATA_IDLE;
      st_ff.bus.addr <= ofr_pkg::BUS_IDLE;
      st_ff.bus.fetch_indicator_n <= 1'b1;
      st_ff.bus.memory_request_n <= 1'b1;
      st_ff.bus.read_n <= 1'b1;
      st_ff.bus.refresh_strobe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from flops
  assign addr = st_ff.bus.addr;
  assign fetch_indicator_n = st_ff.bus.fetch_indicator_n;
  assign memory_request_n = st_ff.bus.memory_request_n;
  assign read_n = st_ff.bus.read_n;
  assign refresh_strobe_n = st_ff.bus.refresh_strobe_n;
  assign opcode = st_ff.ir;
  assign opcode_valid = st_ff.ir_valid;
  assign inserted_wait_state = (st_ff.state == ofr_pkg::ST_TW);
  assign refresh_reg = st_ff.rr;

  // Refresh strobe low only while refresh address is out and fetch indicator high
  property p_refresh_strobe_n_addr;
    @(posedge clk) disable iff (!rst_n)
      !refresh_strobe_n |-> (addr[15:7] == 9'h000) && fetch_indicator_n;
  endproperty
  a_refresh_strobe_n_addr: assert property (p_refresh_strobe_n_addr) else $error("refresh strobe without refresh address");
  // Fetch indicator and refresh never overlap
  property p_m1_excl;
    @(posedge clk) disable iff (!rst_n) !fetch_indicator_n |-> refresh_strobe_n;
  endproperty
  a_m1_excl: assert property (p_m1_excl) else $error("fetch indicator overlaps refresh");
  // Fetch phase drives request, read and fetch together
  property p_fetch_strobes;
    @(posedge clk) disable iff (!rst_n) !fetch_indicator_n |-> !memory_request_n && !read_n && addr == st_ff.pc;
  endproperty
  a_fetch_strobes: assert property (p_fetch_strobes) else $error("fetch strobes mismatch");
  // Opcode latched from synchronised data
  property p_latch;
    @(posedge clk) disable iff (!rst_n) opcode_valid |-> opcode == $past(st_ff.d_s2);
  endproperty
  a_latch: assert property (p_latch) else $error("opcode not latched");
  // Leaving wait only with wait high
  property p_wait;
    @(posedge clk) disable iff (!rst_n)
      (st_ff.state == ofr_pkg::ST_TW) && tick && st_ff.phase_hi && !st_ff.wait_s2 |=> st_ff.state == ofr_pkg::ST_TW;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state left while wait low");
  // Refresh row advances once per cycle, top bit kept
  property p_row;
    @(posedge clk) disable iff (!rst_n)
      $changed(st_ff.rr) |-> st_ff.rr == next_row($past(st_ff.rr)) && st_ff.state == ofr_pkg::ST_T1;
  endproperty
  a_row: assert property (p_row) else $error("refresh row step wrong");
  // Request is released while refresh strobe still low in T4
  property p_t4;
    @(posedge clk) disable iff (!rst_n) st_ff.state == ofr_pkg::ST_T4 |-> memory_request_n && !refresh_strobe_n;
  endproperty
  a_t4: assert property (p_t4) else $error("T4 strobes wrong");
  // After T4 comes T1
  property p_next;
    @(posedge clk) disable iff (!rst_n)
      st_ff.state == ofr_pkg::ST_T4 ##1 st_ff.state != ofr_pkg::ST_T4 |-> st_ff.state == ofr_pkg::ST_T1;
  endproperty
  a_next: assert property (p_next) else $error("T4 not followed by T1");
  // Reset holds every control inactive and the address bus high
  property p_reset_idle;
    @(posedge clk) !rst_n ##1 !rst_n |-> addr == ofr_pkg::BUS_IDLE && fetch_indicator_n && memory_request_n
      && read_n && refresh_strobe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle during reset");
  // First edge after release starts a fetch at the reset address
  property p_reset_fetch;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |=> addr == ofr_pkg::RESET_PC && !memory_request_n && !fetch_indicator_n;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("no fetch from reset address");
  // Opcode capture, fetch release and refresh start share one edge
  property p_latch_edge;
    @(posedge clk) disable iff (!rst_n) opcode_valid |-> $fell(refresh_strobe_n) && $rose(fetch_indicator_n);
  endproperty
  a_latch_edge: assert property (p_latch_edge) else $error("refresh not started at opcode capture");
  // Wait high at the end of T2 or a wait state moves on and latches the opcode
  property p_wait_go;
    @(posedge clk) disable iff (!rst_n)
      (st_ff.state == ofr_pkg::ST_T2 || st_ff.state == ofr_pkg::ST_TW) && tick && st_ff.phase_hi && st_ff.wait_s2
      |=> st_ff.state == ofr_pkg::ST_T3 && opcode_valid;
  endproperty
  a_wait_go: assert property (p_wait_go) else $error("wait high did not reach T3");
  // Refresh access: request first stays released, then falls while refresh strobe is low
  // Limitation: the window suits half states up to 300 clocks; a larger divider needs a wider bound
  sequence s_refresh_start;
    $fell(refresh_strobe_n) && memory_request_n;
  endsequence
  sequence s_refresh_access;
    ##[1:300] (!memory_request_n && !refresh_strobe_n);
  endsequence
  property p_refresh_strobe_n_access;
    @(posedge clk) disable iff (!rst_n) s_refresh_start |-> s_refresh_access;
  endproperty
  a_refresh_strobe_n_access: assert property (p_refresh_strobe_n_access) else $error("refresh request not reasserted");
  // Refresh strobe rises exactly as the next state one begins
  property p_new_cycle;
    @(posedge clk) disable iff (!rst_n)
      $rose(refresh_strobe_n) |-> !fetch_indicator_n && !memory_request_n && st_ff.state == ofr_pkg::ST_T1;
  endproperty
  a_new_cycle: assert property (p_new_cycle) else $error("refresh end without new fetch");
endmodule : ofr_seq

// ---- bench/ofr_mem.sv ----
// Memory partner: program store with a wait generator and a refresh-safe data bus
`timescale 1ns/1ps
module ofr_mem (
  // Clock
  input wire logic clk,
  // Bus from the sequencer
  input wire ofr_pkg::ofr_bus_type bus,
  // Clocks of wait held low per fetch
  input wire logic [7:0] slow_cycles,
  // Answers
  output logic wait_n,
  output logic [7:0] data_in
);
  logic [7:0] left; // Wait clocks still owed
  logic rd_last; // Read strobe at the previous edge
  // Stored byte of an address; cheap mix so neighbours differ
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mem_byte
  initial begin
    left = 8'h00;
    rd_last = 1'b1;
    wait_n = 1'b1;
    data_in = 8'ha5;
  end
  // Answers move just after the edge, as a real memory would
  always @(posedge clk) begin
    #1;
    if (rd_last && !bus.read_n) begin
      left = slow_cycles;
    end else if (left != 8'h00) begin
      left = left - 8'h01;
    end
    rd_last = bus.read_n;
    wait_n = (left == 8'h00);
    if (!bus.memory_request_n && !bus.read_n) begin
      data_in = mem_byte(bus.addr);
    end else begin
      // Request without read is a refresh: no column access, bus not driven, so it flips
      data_in = ~data_in;
    end
  end
endmodule : ofr_mem

// ---- bench/opcode_fetch_refresh_cycle_test.sv ----
// Self-checking bench for the opcode fetch and refresh sequencer
`timescale 1ns/1ps
module opcode_fetch_refresh_cycle_test;
  localparam int DIV = 2; // Short states keep the run brief
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wait_n, fetch_indicator_n, memory_request_n, read_n, refresh_strobe_n, opcode_valid, inserted_wait_state;
  logic [7:0] data_in, opcode, refresh_reg;
  logic [7:0] slow_cycles = 8'h00;
  logic [15:0] addr;
  ofr_pkg::ofr_bus_type bus;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] pc; // Address of the fetch under way
  logic [6:0] row; // Row the next refresh should show
  assign bus = {addr, fetch_indicator_n, memory_request_n, read_n, refresh_strobe_n};
  ofr_seq #(.DIV(DIV)) i_ofr_seq (.clk(clk), .rst_n(rst_n), .wait_n(wait_n), .data_in(data_in), .addr(addr),
    .fetch_indicator_n(fetch_indicator_n), .memory_request_n(memory_request_n), .read_n(read_n),
    .refresh_strobe_n(refresh_strobe_n), .opcode(opcode), .opcode_valid(opcode_valid),
    .inserted_wait_state(inserted_wait_state), .refresh_reg(refresh_reg));
  ofr_mem i_ofr_mem (.clk(clk), .bus(bus), .slow_cycles(slow_cycles), .wait_n(wait_n), .data_in(data_in));
  // Clock and hang guard; a full run needs about 2200 cycles
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // Compare a bus value
  task automatic chk_bus(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus
  // Compare a single strobe
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  // Sample point: settled, well after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  // Byte the memory model holds at an address, kept here so the bench needs no peek into it
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : exp_byte
  function automatic logic sig(input int k);
    case (k)
      0: return opcode_valid;
      1: return refresh_strobe_n;
      2: return memory_request_n;
      default: return inserted_wait_state;
    endcase
  endfunction : sig
  // Bounded wait for a watched output to reach a level
  task automatic await(input int k, input logic v);
    int n = 0;
    while (n < 40 && sig(k) !== v) begin
      step(1);
      n++;
    end
    chk_bit(sig(k), v);
  endtask : await
  // Reset in mid-run too: idle levels, then restart at address zero
  task automatic reset_check();
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    step(2);
    chk_bus(addr, 16'hffff);
    chk_bus({fetch_indicator_n, memory_request_n, read_n, refresh_strobe_n}, 16'h000f);
    chk_bus(refresh_reg, 16'h0000);
    repeat (13) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    chk_bus(addr, 16'h0000);
    chk_bus({fetch_indicator_n, memory_request_n, read_n}, 16'h0000);
    pc = 16'h0000;
    row = 7'h00;
  endtask : reset_check
  // One whole fetch, optionally stretched by the memory
  task automatic fetch_one(input logic stretch);
    if (stretch) begin
      await(3, 1'b1);
      chk_bit(fetch_indicator_n, 1'b0);
      chk_bit(read_n, 1'b0);
      chk_bus(addr, pc);
    end
    await(0, 1'b1);
    chk_bus(opcode, exp_byte(pc));
    chk_bit(inserted_wait_state, 1'b0);
    step(1);
    chk_bit(opcode_valid, 1'b0);
    await(1, 1'b0);
    chk_bit(memory_request_n, 1'b1);
    chk_bus(addr, {9'h000, row});
    chk_bit(fetch_indicator_n, 1'b1);
    chk_bit(read_n, 1'b1);
    await(2, 1'b0);
    chk_bit(refresh_strobe_n, 1'b0);
    await(2, 1'b1);
    chk_bit(refresh_strobe_n, 1'b0);
    chk_bus(addr, {9'h000, row});
    await(1, 1'b1);
    chk_bus(addr, pc + 16'h0001);
    chk_bit(memory_request_n, 1'b0);
    pc = pc + 16'h0001;
    row = row + 7'h01;
    step(1);
    chk_bus(refresh_reg, {9'h000, row});
  endtask : fetch_one
  initial begin
    reset_check();
    fetch_one(1'b0);
    slow_cycles = 8'h0a;
    fetch_one(1'b0);
    fetch_one(1'b1);
    slow_cycles = 8'h00;
    repeat (130) fetch_one(1'b0);
    reset_check();
    fetch_one(1'b0);
    finish_test();
  end
endmodule : opcode_fetch_refresh_cycle_test
